// ---- hw/rate_gen_pkg.sv ----
// Purpose: constants for the serial port rate generator and pin control
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are chosen locally
package rate_gen_pkg;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  RATE_CTRL_OFS   = 4'h0;
  localparam logic [3:0]  PIN_CTRL_OFS    = 4'h4;
  localparam logic [3:0]  PORT_CTRL_OFS   = 4'h8;
  localparam logic [3:0]  STATUS_OFS      = 4'hC;
  // rate generator control fields
  localparam int          SRC_SEL_BIT     = 29;
  localparam int          FS_MODE_BIT     = 28;
  localparam int          PER_LSB         = 16;
  localparam int          PER_W           = 12;
  localparam int          WID_LSB         = 8;
  localparam int          WID_W           = 8;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_W           = 8;
  localparam logic [31:0] RATE_CTRL_MASK  = 32'h3FFF_FFFF;
  localparam logic [31:0] RATE_CTRL_RST   = 32'h2000_0001;
  // pin direction control fields
  localparam int          TX_FS_SRC_BIT   = 11;
  localparam int          RX_FS_SRC_BIT   = 10;
  localparam int          TX_CLK_SRC_BIT  = 9;
  localparam int          RX_CLK_SRC_BIT  = 8;
  localparam int          PIN_CLK_EN_BIT  = 7;
  localparam logic [31:0] PIN_CTRL_MASK   = 32'h0000_3FAF;
  localparam logic [31:0] PIN_CTRL_RST    = 32'h0000_0000;
  // port control: loopback
  localparam int          LOOPBACK_BIT    = 15;
  localparam logic [31:0] PORT_CTRL_MASK  = 32'h0000_8000;
  localparam logic [31:0] PORT_CTRL_RST   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ---- hw/serial_port_rate_gen_pin_ctrl.sv ----
// Purpose: rate generator (bit clock, frame pulse) and pin direction control
// Assumes: pin inputs synchronous to clk; divider runs on clk-domain edges
// Notes:   Function list below
// Function
// RULE1: input clock: rx pin, internal clock or tx pin by select and enable bits
// RULE2: internal tx frame sync with mode 1 follows generator frame pulse
// RULE3: mode 0 pulses tx frame sync on each holding-to-shift copy
// RULE4: frame pulses spaced period field plus one bit clocks
// RULE5: frame pulse active width field plus one bit clocks
// RULE6: divider field is the bit clock divide-down count
// RULE7: bit clock equals input clock over divider plus one; on clk, divider 0 holds it high
// RULE8: reset selects internal clock and divides by two
// RULE9: tx frame sync external at 0, internal at 1
// RULE10: rx frame sync pin input at 0, generator output at 1
// RULE11: tx clock pin input at 0, generator bit clock at 1
// RULE12: without loopback rx clock pin input at 0, generator clock at 1
// RULE13: loopback with rx clock bit 0: receiver uses tx clock, pin released
// RULE14: loopback with rx clock bit 1: rx clock pin carries tx clock
// RULE15: reserved bits read zero, writes ignored; the code stores reserved pin-control bits 13-12 as written and reads them back
// RULE16: software writes zero to reserved pin-control bits 13-12
// RULE17: pin-control fields reset zero, all pins inputs
// RULE18: frame counter asserts pulse at period start for programmed width
`timescale 1ns/1ps
module serial_port_rate_gen_pin_ctrl
  import rate_gen_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // axi4-lite write address, data and response
  input  wire logic [rate_gen_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [rate_gen_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // transmit path event
  input  wire logic                        tx_copy_pulse,
  // transmit clock pin
  input  wire logic                        tx_serial_clock_in,
  output logic                             tx_serial_clock_out,
  output logic                             tx_serial_clock_oe_n,
  // receive clock pin
  input  wire logic                        rx_serial_clock_in,
  output logic                             rx_serial_clock_out,
  output logic                             rx_serial_clock_oe_n,
  // transmit frame sync pin
  input  wire logic                        tx_frame_sync_in,
  output logic                             tx_frame_sync_out,
  output logic                             tx_frame_sync_oe_n,
  // receive frame sync pin
  input  wire logic                        rx_frame_sync_in,
  output logic                             rx_frame_sync_out,
  output logic                             rx_frame_sync_oe_n,
  // internal clocks and frame syncs to the shifters
  output logic                             tx_clock_int,
  output logic                             rx_clock_int,
  output logic                             tx_frame_int,
  output logic                             rx_frame_int
);
  import rate_gen_pkg::*;

  typedef struct packed {
    logic [31:0]      rate_ctrl;
    logic [31:0]      pin_ctrl;
    logic [31:0]      port_ctrl;
    logic             aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             src_prev;
    logic [DIV_W-1:0] div_cnt;
    logic             bit_clk;
    logic [PER_W-1:0] per_cnt;
    logic [WID_W:0]   wid_cnt;
    logic             frame;
    logic             copy_fs;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    return (a == RATE_CTRL_OFS) || (a == PIN_CTRL_OFS) || (a == PORT_CTRL_OFS)
           || (a == STATUS_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoded configuration
  logic             src_sel;
  logic             pin_clk_en;
  logic             fs_mode;
  logic             tx_fs_src;
  logic             rx_fs_src;
  logic             tx_clk_src;
  logic             rx_clk_src;
  logic             loopback;
  logic             gen_input;
  logic             gen_bit_clock;
  logic             gen_frame_pulse;
  logic             tx_clock;
  logic [DIV_W-1:0] bit_clock_divider;
  logic [PER_W-1:0] frame_period;
  logic [WID_W-1:0] frame_width;
  logic             gen_edge;
  logic             int_src;
  logic [DIV_W-1:0] div_cnt_nxt;
  logic             bit_clk_nxt;
  logic             bit_rise;
  logic             wr_go;
  logic [31:0]      status;

  assign src_sel           = state_reg.rate_ctrl[SRC_SEL_BIT];
  assign fs_mode           = state_reg.rate_ctrl[FS_MODE_BIT];
  assign frame_period      = state_reg.rate_ctrl[PER_LSB +: PER_W];
  assign frame_width       = state_reg.rate_ctrl[WID_LSB +: WID_W];
  assign bit_clock_divider = state_reg.rate_ctrl[DIV_LSB +: DIV_W];
  assign pin_clk_en        = state_reg.pin_ctrl[PIN_CLK_EN_BIT];
  assign tx_fs_src         = state_reg.pin_ctrl[TX_FS_SRC_BIT];
  assign rx_fs_src         = state_reg.pin_ctrl[RX_FS_SRC_BIT];
  assign tx_clk_src        = state_reg.pin_ctrl[TX_CLK_SRC_BIT];
  assign rx_clk_src        = state_reg.pin_ctrl[RX_CLK_SRC_BIT];
  assign loopback          = state_reg.port_ctrl[LOOPBACK_BIT];
  assign gen_bit_clock     = state_reg.bit_clk;
  assign gen_frame_pulse   = state_reg.frame;

  // selected generator input; the reserved 0/0 combination falls to the rx pin
  always_comb begin
    if (src_sel) begin
      gen_input = pin_clk_en ? tx_serial_clock_in : 1'b0; // [RULE1]
    end else begin
      gen_input = rx_serial_clock_in; // [RULE1]
    end
  end
  // clk counts every cycle; a pin source counts both of its edges
  assign int_src  = src_sel && !pin_clk_en; // [RULE1]
  assign gen_edge = int_src ? 1'b1 : (gen_input != state_reg.src_prev);
  assign bit_rise = bit_clk_nxt && !state_reg.bit_clk;
  assign wr_go    = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign status   = {28'h0000000, gen_frame_pulse, gen_bit_clock, tx_clock, rx_clock_int};
  // period of divider+1 counts; on clk divider 0 holds it high (no clk-rate clock)
  always_comb begin
    div_cnt_nxt = state_reg.div_cnt + 1'b1;
    bit_clk_nxt = state_reg.bit_clk;
    if (state_reg.div_cnt >= bit_clock_divider) begin // [RULE6] [RULE7]
      div_cnt_nxt = '0;
    end
    if (int_src) begin
      bit_clk_nxt = (div_cnt_nxt <= (bit_clock_divider >> 1)); // [RULE7] [RULE8]
    end else if (!gen_edge) begin
      div_cnt_nxt = state_reg.div_cnt;
    end else if (state_reg.div_cnt >= bit_clock_divider) begin
      bit_clk_nxt = !state_reg.bit_clk; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.src_prev = int_src ? 1'b0 : gen_input;
    state_next.div_cnt  = div_cnt_nxt;
    state_next.bit_clk  = bit_clk_nxt;
    // frame pulse counted in bit clock periods
    if (bit_rise) begin
      if (state_reg.per_cnt >= frame_period) begin // [RULE4] [RULE18]
        state_next.per_cnt = '0;
        state_next.frame   = 1'b1;
        state_next.wid_cnt = '0;
      end else begin
        state_next.per_cnt = state_reg.per_cnt + 1'b1;
        state_next.wid_cnt = state_reg.wid_cnt + 1'b1;
        if (state_reg.wid_cnt >= {1'b0, frame_width}) begin // [RULE5]
          state_next.frame = 1'b0;
        end
      end
    end
    state_next.copy_fs = tx_copy_pulse; // [RULE3]
    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = known(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (state_reg.aw_addr)
        RATE_CTRL_OFS: state_next.rate_ctrl = merge(state_reg.rate_ctrl, state_reg.w_data,
                                                    state_reg.w_strb, RATE_CTRL_MASK); // [RULE15]
        PIN_CTRL_OFS:  state_next.pin_ctrl = merge(state_reg.pin_ctrl, state_reg.w_data,
                                                   state_reg.w_strb, PIN_CTRL_MASK); // [RULE15]
        PORT_CTRL_OFS: state_next.port_ctrl = merge(state_reg.port_ctrl, state_reg.w_data,
                                                    state_reg.w_strb, PORT_CTRL_MASK);
        default: begin
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        RATE_CTRL_OFS: state_next.rdata = state_reg.rate_ctrl & RATE_CTRL_MASK;
        PIN_CTRL_OFS:  state_next.rdata = state_reg.pin_ctrl & PIN_CTRL_MASK;
        PORT_CTRL_OFS: state_next.rdata = state_reg.port_ctrl & PORT_CTRL_MASK;
        STATUS_OFS:    state_next.rdata = status;
        default:       state_next.rdata = 32'h0000_0000;
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.rate_ctrl <= RATE_CTRL_RST; // [RULE8]
      state_reg.pin_ctrl  <= PIN_CTRL_RST; // [RULE17]
      state_reg.port_ctrl <= PORT_CTRL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

  ////////////////////////////////////////////////////////////////////////
  // pin direction
  assign tx_clock             = tx_clk_src ? gen_bit_clock : tx_serial_clock_in; // [RULE11]
  assign tx_clock_int         = tx_clock;
  assign tx_serial_clock_out  = gen_bit_clock;
  assign tx_serial_clock_oe_n = !tx_clk_src; // [RULE11] [RULE17]
  always_comb begin
    if (loopback) begin
      rx_clock_int         = tx_clock; // [RULE13] [RULE14]
      rx_serial_clock_out  = tx_clock; // [RULE14]
      rx_serial_clock_oe_n = !rx_clk_src; // [RULE13]
    end else begin
      rx_clock_int         = rx_clk_src ? gen_bit_clock : rx_serial_clock_in; // [RULE12]
      rx_serial_clock_out  = gen_bit_clock;
      rx_serial_clock_oe_n = !rx_clk_src; // [RULE12]
    end
  end
  always_comb begin
    if (!tx_fs_src) begin
      tx_frame_int = tx_frame_sync_in; // [RULE9]
    end else if (fs_mode) begin
      tx_frame_int = gen_frame_pulse; // [RULE2]
    end else begin
      tx_frame_int = state_reg.copy_fs; // [RULE3]
    end
  end
  assign tx_frame_sync_out  = tx_frame_int;
  assign tx_frame_sync_oe_n = !tx_fs_src; // [RULE9]
  assign rx_frame_sync_out  = gen_frame_pulse;
  assign rx_frame_sync_oe_n = !rx_fs_src; // [RULE10]
  assign rx_frame_int       = rx_fs_src ? gen_frame_pulse : rx_frame_sync_in; // [RULE10]

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_oe_tracks_pin_ctrl;
    @(posedge clk) disable iff (!rst_n)
      (tx_serial_clock_oe_n == !tx_clk_src) && (rx_frame_sync_oe_n == !rx_fs_src);
  endproperty
  a_oe_tracks_pin_ctrl: assert property (p_oe_tracks_pin_ctrl) // [RULE10] [RULE11]
    else $error("pin direction does not follow pin control");

  property p_loop_rx_clock;
    @(posedge clk) disable iff (!rst_n)
      loopback |-> (rx_clock_int == tx_clock);
  endproperty
  a_loop_rx_clock: assert property (p_loop_rx_clock) // [RULE13]
    else $error("loopback receive clock not tx clock");

  property p_fs_gen;
    @(posedge clk) disable iff (!rst_n)
      (tx_fs_src && fs_mode) |-> (tx_frame_int == gen_frame_pulse);
  endproperty
  a_fs_gen: assert property (p_fs_gen) // [RULE2]
    else $error("tx frame sync not from generator");

  property p_copy_fs;
    @(posedge clk) disable iff (!rst_n)
      (tx_copy_pulse && tx_fs_src && !fs_mode) ##1 (tx_fs_src && !fs_mode) |-> tx_frame_int;
  endproperty
  a_copy_fs: assert property (p_copy_fs) // [RULE3]
    else $error("copy did not raise tx frame sync");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
      (state_reg.pin_ctrl[31:14] == 18'h0) && (state_reg.rate_ctrl[31:30] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE15]
    else $error("reserved bits set");

  property p_bit_toggle;
    @(posedge clk) disable iff (!rst_n)
      (gen_edge && state_reg.div_cnt >= bit_clock_divider)
      |=> ($past(int_src) ? gen_bit_clock : (gen_bit_clock != $past(gen_bit_clock)));
  endproperty
  a_bit_toggle: assert property (p_bit_toggle) // [RULE6]
    else $error("bit clock failed to toggle at divider end");

  property p_frame_start;
    @(posedge clk) disable iff (!rst_n)
      (bit_rise && state_reg.per_cnt >= frame_period) |=> gen_frame_pulse;
  endproperty
  a_frame_start: assert property (p_frame_start) // [RULE4] [RULE18]
    else $error("frame pulse missed period start");

  property p_frame_end;
    @(posedge clk) disable iff (!rst_n)
      (bit_rise && state_reg.per_cnt < frame_period && state_reg.wid_cnt >= {1'b0, frame_width})
      |=> !gen_frame_pulse;
  endproperty
  a_frame_end: assert property (p_frame_end) // [RULE5]
    else $error("frame pulse exceeded width");

endmodule // serial_port_rate_gen_pin_ctrl

// ---- testbench/codec_model.sv ----
// Purpose: external codec driving the serial clock and frame sync pins
// Assumes: pins resolved by the bench from the device output enables
// Notes:   clocks stand still while run is low
`timescale 1ns/1ps
module codec_model #(
  parameter int TX_HALF   = 5,
  parameter int RX_HALF   = 3,
  parameter int FS_PERIOD = 16
) (
  // clock, reset and traffic enable
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  // levels the codec puts on the pins
  output logic      tck,
  output logic      rck,
  output logic      tfs,
  output logic      rfs
);
  int tcnt;
  int rcnt;
  int fcnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck  <= 1'b0;
      rck  <= 1'b0;
      tfs  <= 1'b0;
      rfs  <= 1'b0;
      tcnt <= 0;
      rcnt <= 0;
      fcnt <= 0;
    end else if (!run) begin
      tck  <= 1'b0;
      rck  <= 1'b0;
      tfs  <= 1'b0;
      rfs  <= 1'b0;
      tcnt <= 0;
      rcnt <= 0;
      fcnt <= 0;
    end else begin
      tcnt <= (tcnt == TX_HALF - 1) ? 0 : tcnt + 1;
      rcnt <= (rcnt == RX_HALF - 1) ? 0 : rcnt + 1;
      fcnt <= (fcnt == FS_PERIOD - 1) ? 0 : fcnt + 1;
      if (tcnt == TX_HALF - 1) tck <= !tck;
      if (rcnt == RX_HALF - 1) rck <= !rck;
      // offset syncs so a swapped mux shows
      tfs <= (fcnt == 0);
      rfs <= (fcnt == 5);
    end
  end
endmodule // codec_model

// ---- testbench/serial_port_rate_gen_pin_ctrl_bench.sv ----
// Purpose: register and pin level tests of the rate generator
// Assumes: AXI4-Lite master tasks, codec model on the far side
// Notes:   periods measured in clk cycles at negedge
`timescale 1ns/1ps
module serial_port_rate_gen_pin_ctrl_bench;
  import rate_gen_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, copy = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic tck_o, tck_oe_n, rck_o, rck_oe_n, tfs_o, tfs_oe_n, rfs_o, rfs_oe_n;
  logic m_tck, m_rck, m_tfs, m_rfs, tck_i, rck_i, tfs_i, rfs_i, tx_ck, rx_ck, tx_fr, rx_fr;
  int error_cnt = 0, n_tests = 0;
  logic [7:0] divs [4] = '{8'h01, 8'h02, 8'h04, 8'hFF};
  wire logic [3:0] oe  = {tck_oe_n, rck_oe_n, tfs_oe_n, rfs_oe_n};
  wire logic [3:0] mon = {rfs_o, tfs_o, rck_o, tck_o};

  always #5 clk = ~clk;
  assign tck_i = tck_oe_n ? m_tck : tck_o;
  assign rck_i = rck_oe_n ? m_rck : rck_o;
  assign tfs_i = tfs_oe_n ? m_tfs : tfs_o;
  assign rfs_i = rfs_oe_n ? m_rfs : rfs_o;

  codec_model codec (.clk(clk), .rst_n(rst_n), .run(run),
    .tck(m_tck), .rck(m_rck), .tfs(m_tfs), .rfs(m_rfs));

  serial_port_rate_gen_pin_ctrl uut (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_copy_pulse(copy),
    .tx_serial_clock_in(tck_i), .tx_serial_clock_out(tck_o),
    .tx_serial_clock_oe_n(tck_oe_n), .rx_serial_clock_in(rck_i),
    .rx_serial_clock_out(rck_o), .rx_serial_clock_oe_n(rck_oe_n),
    .tx_frame_sync_in(tfs_i), .tx_frame_sync_out(tfs_o), .tx_frame_sync_oe_n(tfs_oe_n),
    .rx_frame_sync_in(rfs_i), .rx_frame_sync_out(rfs_o), .rx_frame_sync_oe_n(rfs_oe_n),
    .tx_clock_int(tx_ck), .rx_clock_int(rx_ck), .tx_frame_int(tx_fr), .rx_frame_int(rx_fr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out();
    $display("wait limit reached at %0t", $time);
    error_cnt++;
    give_verdict();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw_ok, w_ok, b_ok;
    int n;
    b_ok = 0;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_ok && n < 100) begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = (bvalid === 1'b1);
      n++;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
    if (!b_ok) timed_out();
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bit ar_ok, r_ok;
    int n;
    r_ok = 0;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_ok && n < 100) begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok = (rvalid === 1'b1);
      d = rdata;
      n++;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
    if (!r_ok) timed_out();
  endtask

  // skips one period so a config change has settled before counting
  task automatic measure(input int idx, input logic [31:0] exp_hi, input logic [31:0] exp_per);
    logic prev;
    int hi, per, n;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      do begin
        prev = mon[idx];
        @(negedge clk);
        n++;
      end while (!(prev === 1'b0 && mon[idx] === 1'b1) && n < 3000);
    end
    hi = 0;
    per = 0;
    do begin
      if (mon[idx] === 1'b1) hi++;
      prev = mon[idx];
      @(negedge clk);
      per++;
      n++;
    end while (!(prev === 1'b0 && mon[idx] === 1'b1) && n < 3000);
    if (n >= 3000) timed_out();
    check(32'(hi), exp_hi);
    check(32'(per), exp_per);
  endtask

  function automatic logic [31:0] mkrate(input logic src, input logic fsm,
      input logic [11:0] per, input logic [7:0] wid, input logic [7:0] div);
    return {2'b00, src, fsm, per, wid, div};
  endfunction

  // bits 13-12 always written as zero
  function automatic logic [31:0] mkpin(input logic txfs, input logic rxfs,
      input logic txc, input logic rxc, input logic en);
    return {18'h0, 2'b00, txfs, rxfs, txc, rxc, en, 7'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    int highs;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(RATE_CTRL_OFS, v);
    check(v, 32'h2000_0001);
    rd(PIN_CTRL_OFS, v);
    check(v, 32'h0);
    rd(PORT_CTRL_OFS, v);
    check(v, 32'h0);
    check(32'(oe), 32'hF);
    wr(PIN_CTRL_OFS, mkpin(0, 0, 1, 0, 0));
    check(32'(bresp), 32'(RESP_OKAY));
    measure(0, 32'd1, 32'd2);
    $display("test reset values done");
    wr(RATE_CTRL_OFS, 32'hFFFF_FFFF);
    rd(RATE_CTRL_OFS, v);
    check(v, 32'hFFFF_FFFF & RATE_CTRL_MASK);
    wr(PIN_CTRL_OFS, 32'hFFFF_CFFF);
    rd(PIN_CTRL_OFS, v);
    check(v, 32'hFFFF_CFFF & PIN_CTRL_MASK);
    rd(4'h2, v);
    check(v, 32'h0);
    check(32'(rresp), 32'(RESP_SLVERR));
    wr(4'h2, 32'hFFFF_CFFF);
    check(32'(bresp), 32'(RESP_SLVERR));
    $display("test reserved bits done");
    wr(PIN_CTRL_OFS, mkpin(0, 0, 1, 0, 0));
    foreach (divs[i]) begin
      wr(RATE_CTRL_OFS, mkrate(1, 1, 12'h0, 8'h0, divs[i]));
      measure(0, 32'(divs[i]) / 2 + 1, 32'(divs[i]) + 1);
    end
    $display("test divider done");
    wr(PIN_CTRL_OFS, mkpin(1, 1, 1, 0, 0));
    wr(RATE_CTRL_OFS, mkrate(1, 1, 12'd9, 8'd2, 8'd1));
    check(32'(oe), 32'h4);
    measure(3, 32'd6, 32'd20);
    measure(2, 32'd6, 32'd20);
    $display("test frame generator done");
    wr(RATE_CTRL_OFS, mkrate(1, 0, 12'd9, 8'd2, 8'd1));
    repeat (50) @(posedge clk);
    copy <= 1'b1;
    @(negedge clk);
    check(32'(tx_fr), 32'h0);
    @(posedge clk);
    copy <= 1'b0;
    @(negedge clk);
    check(32'(tx_fr), 32'h1);
    repeat (3) @(negedge clk);
    highs = 0;
    repeat (60) begin
      @(negedge clk);
      if (tx_fr !== 1'b0) highs++;
    end
    check(32'(highs), 32'h0);
    $display("test copy frame sync done");
    @(posedge clk);
    run <= 1'b1;
    wr(PIN_CTRL_OFS, mkpin(0, 0, 0, 0, 0));
    check(32'(oe), 32'hF);
    repeat (40) begin
      @(negedge clk);
      check({28'h0, tx_fr, rx_fr, tx_ck, rx_ck}, {28'h0, tfs_i, rfs_i, tck_i, rck_i});
    end
    $display("test external pins done");
    wr(PIN_CTRL_OFS, mkpin(0, 0, 1, 0, 1));
    wr(RATE_CTRL_OFS, mkrate(0, 1, 12'h0, 8'h0, 8'h0));
    measure(0, 32'd3, 32'd6);
    wr(PIN_CTRL_OFS, mkpin(0, 0, 0, 1, 1));
    wr(RATE_CTRL_OFS, mkrate(1, 1, 12'h0, 8'h0, 8'h0));
    check(32'(oe), 32'hB);
    measure(1, 32'd5, 32'd10);
    $display("test clock source done");
    wr(PIN_CTRL_OFS, mkpin(0, 0, 1, 0, 0));
    wr(RATE_CTRL_OFS, mkrate(1, 1, 12'h0, 8'h0, 8'h1));
    wr(PORT_CTRL_OFS, 32'h0000_8000);
    check(32'(rck_oe_n), 32'h1);
    repeat (16) begin
      @(negedge clk);
      check(32'(rx_ck), 32'(tx_ck));
    end
    wr(PIN_CTRL_OFS, mkpin(0, 0, 1, 1, 0));
    check(32'(rck_oe_n), 32'h0);
    measure(1, 32'd1, 32'd2);
    wr(PIN_CTRL_OFS, mkpin(0, 0, 0, 1, 0));
    measure(1, 32'd5, 32'd10);
    $display("test loopback done");
    give_verdict();
  end
endmodule // serial_port_rate_gen_pin_ctrl_bench
